// ==== logic/pmw_pkg.sv ====
// package for the power-mode wake and reset-cause block
// assumes an axi4-lite register bus with 32-bit data and one word per register
package pmw_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h00; // reset_cause_control
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

   // ----------------------------------------------------------------
   // reset_cause_control fields and reset value
   // ----------------------------------------------------------------
   localparam int RC_PRIO_EN = 7;
   localparam int RC_CFG_MISMATCH = 5;
   localparam int RC_RESET_INSTR = 4;
   localparam int RC_WDT_TIMEOUT = 3;
   localparam int RC_POWER_DOWN = 2;
   localparam int RC_POWER_ON = 1;
   localparam int RC_BROWN_OUT = 0;
   localparam logic [7:0] RC_RESET_VAL = 8'h3C;
   localparam logic [7:0] RC_SW_MASK = 8'hB3; // software-writable bits

   // ----------------------------------------------------------------
   // system_clock_select codes and clock source codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SCS_SECONDARY = 2'h1;
   localparam logic [1:0] SCS_PRIMARY = 2'h2;
   localparam logic [1:0] SRC_PRIMARY = 2'h0;
   localparam logic [1:0] SRC_SECONDARY = 2'h1;
   localparam logic [1:0] SRC_INTERNAL = 2'h2;
   localparam logic [7:0] CTRL_RESET_VAL = 8'h04; // primary selected, idle off

   // ----------------------------------------------------------------
   // interrupt status bits
   // ----------------------------------------------------------------
   localparam int IRQ_W = 4;
   localparam int IRQ_WAKE_DONE = 0;
   localparam int IRQ_WDT_RESET = 1;
   localparam int IRQ_CLK_LOST = 2;
   localparam int IRQ_RESET_EXIT = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned WAKE_DELAY_CYC = 8; // cpu_wake_delay in clock cycles
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // axi responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // power-mode states
   typedef enum logic [2:0] {
      PMW_RUN,
      PMW_IDLE,
      PMW_SLEEP,
      PMW_OST_WAIT,
      PMW_WAKE
   } pmw_state_t;

   // control register layout
   typedef struct packed {
      logic ext_clk_mode;       // primary is external_clock_mode or _pll_mode
      logic fscm_en;            // fail-safe clock monitor enable
      logic wdt_en;             // watchdog enable
      logic global_irq_en;      // global_interrupt_enable
      logic [1:0] sys_clk_sel;  // system_clock_select
      logic idle_on_sleep_en;   // idle_on_sleep_enable
   } pmw_ctrl_t;

   // clock control outputs
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic primary_osc_en;
      logic internal_osc_en;
      logic [1:0] clk_src;
   } pmw_clk_t;

endpackage

// ==== logic/pmw_power_wake.sv ====
// power-mode sequencer: idle and sleep entry, wake exits, reset-cause register
// assumes one 40 mhz clock, axi4-lite master, cpu core giving one-cycle
// instruction strobes, and a start-up timer that reports the primary ready
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module pmw_power_wake #(
   parameter int unsigned WAKE_DELAY_CYC = pmw_pkg::WAKE_DELAY_CYC,
   parameter int unsigned IRQ_SRC_N = 8
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu core strobes
   input wire logic i_sleep_instr,
   input wire logic i_wdt_clear_instr,
   input wire logic i_reset_instr,
   // interrupt sources
   input wire logic [IRQ_SRC_N-1:0] i_irq_flags,
   input wire logic [IRQ_SRC_N-1:0] i_irq_enables,
   // watchdog, clock monitor, start-up timer
   input wire logic i_wdt_timeout,
   input wire logic i_clk_lost,
   input wire logic i_ost_done,
   // reset event sources
   input wire logic i_por_event,
   input wire logic i_bor_event,
   input wire logic i_cfg_mismatch_event,
   input wire logic i_master_clear_n,
   // clock control
   output pmw_pkg::pmw_clk_t o_clk,
   output logic o_primary_clock_running,
   output logic o_ost_req,
   // cpu and watchdog control
   output logic o_resume,
   output logic o_vector_branch,
   output logic o_wdt_clear,
   output logic o_wdt_reset,
   output logic o_interrupt_priority_en,
   // block interrupt
   output logic o_irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   pmw_pkg::pmw_state_t state;
   pmw_pkg::pmw_ctrl_t ctrl;
   pmw_pkg::pmw_clk_t next_clk;
   logic [7:0] rcause;
   logic [pmw_pkg::IRQ_W-1:0] irq_status;
   logic [pmw_pkg::IRQ_W-1:0] irq_enable;
   logic [pmw_pkg::IRQ_W-1:0] irq_events;
   logic [pmw_pkg::CNT_W-1:0] wake_cnt;
   logic [IRQ_SRC_N-1:0] irq_prev;
   logic master_clear_pin_meta;
   logic master_clear_pin_sync;
   logic master_clear_pin_prev;
   logic master_clear_pin_event;
   logic reset_event;
   logic irq_rise;
   logic low_power;
   logic force_internal;
   logic wake_by_irq;
   logic [1:0] eff_src;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic rd_fire;
   logic wr_rc;
   logic wr_ctrl;
   logic wr_clr;
   logic wr_en;

   // decode of an address against the register map
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == pmw_pkg::ADDR_RESET_CAUSE) || (a == pmw_pkg::ADDR_CTRL) ||
                    (a == pmw_pkg::ADDR_STATUS) || (a == pmw_pkg::ADDR_IRQ_STATUS) ||
                    (a == pmw_pkg::ADDR_IRQ_CLEAR) || (a == pmw_pkg::ADDR_IRQ_ENABLE);
   endfunction

   // source picked by the system_clock_select code
   function automatic logic [1:0] src_of(input logic [1:0] system_clock_select);
      if (system_clock_select == pmw_pkg::SCS_PRIMARY) begin
         src_of = pmw_pkg::SRC_PRIMARY;
      end else if (system_clock_select == pmw_pkg::SCS_SECONDARY) begin
         src_of = pmw_pkg::SRC_SECONDARY;
      end else begin
         src_of = pmw_pkg::SRC_INTERNAL;
      end
   endfunction

   // ----------------------------------------------------------------
   // master clear pin synchroniser and event detection
   // ----------------------------------------------------------------
   // two flops, then edge detect on the second
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         master_clear_pin_meta <= 1'b1;
         master_clear_pin_sync <= 1'b1;
         master_clear_pin_prev <= 1'b1;
      end else begin
         master_clear_pin_meta <= i_master_clear_n;
         master_clear_pin_sync <= master_clear_pin_meta;
         master_clear_pin_prev <= master_clear_pin_sync;
      end
   end

   assign master_clear_pin_event = master_clear_pin_prev && !master_clear_pin_sync;
   assign reset_event = master_clear_pin_event || i_por_event || i_bor_event ||
                        i_reset_instr || i_cfg_mismatch_event;
   assign low_power = (state == pmw_pkg::PMW_IDLE) || (state == pmw_pkg::PMW_SLEEP);

   // remember flags to see a flag becoming set
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         irq_prev <= '0;
      end else begin
         irq_prev <= i_irq_flags;
      end
   end

   assign irq_rise = |(i_irq_flags & ~irq_prev & i_irq_enables);

   // ----------------------------------------------------------------
   // power-mode state machine
   // ----------------------------------------------------------------
   // exits only by irq, reset, watchdog
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         state <= pmw_pkg::PMW_RUN;
         wake_cnt <= '0;
         wake_by_irq <= 1'b0;
      end else begin
         unique case (state)
            pmw_pkg::PMW_RUN: begin
               // sleep instruction picks idle or sleep
               if (i_sleep_instr && !reset_event) begin
                  state <= ctrl.idle_on_sleep_en ? pmw_pkg::PMW_IDLE : pmw_pkg::PMW_SLEEP;
               end
            end
            pmw_pkg::PMW_IDLE, pmw_pkg::PMW_SLEEP: begin
               if (reset_event || irq_rise || i_wdt_timeout) begin
                  wake_by_irq <= irq_rise && !reset_event;
                  wake_cnt <= pmw_pkg::CNT_W'(WAKE_DELAY_CYC - 1);
                  // start-up wait only if primary not ready
                  if (!reset_event && eff_src == pmw_pkg::SRC_PRIMARY &&
                      !o_primary_clock_running && !ctrl.ext_clk_mode) begin
                     state <= pmw_pkg::PMW_OST_WAIT;
                  end else begin
                     state <= pmw_pkg::PMW_WAKE;
                  end
               end
            end
            pmw_pkg::PMW_OST_WAIT: begin
               if (o_primary_clock_running) begin
                  state <= pmw_pkg::PMW_WAKE;
               end
            end
            pmw_pkg::PMW_WAKE: begin
               if (wake_cnt == '0) begin
                  state <= pmw_pkg::PMW_RUN;
               end else begin
                  wake_cnt <= wake_cnt - 1'b1;
               end
            end
         endcase
      end
   end

   // resume strobe and vector decision
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_resume <= 1'b0;
         o_vector_branch <= 1'b0;
      end else begin
         o_resume <= (state == pmw_pkg::PMW_WAKE) && (wake_cnt == '0);
         o_vector_branch <= (state == pmw_pkg::PMW_WAKE) && (wake_cnt == '0) &&
                            wake_by_irq && ctrl.global_irq_en;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_wdt_reset <= 1'b0;
      end else begin
         o_wdt_reset <= i_wdt_timeout && (state == pmw_pkg::PMW_RUN);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_wdt_clear <= 1'b0;
      end else begin
         o_wdt_clear <= (i_sleep_instr && state == pmw_pkg::PMW_RUN) || i_wdt_clear_instr ||
                        (i_clk_lost && ctrl.fscm_en);
      end
   end

   // ----------------------------------------------------------------
   // clock control
   // ----------------------------------------------------------------
   // reset exit forces internal clock until software rewrites ctrl
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         force_internal <= 1'b0;
      end else if (reset_event && low_power) begin
         force_internal <= 1'b1;
      end else if (wr_ctrl) begin
         force_internal <= 1'b0;
      end
   end

   // wake into the selected run mode, or internal while a reset exit forces it
   assign eff_src = force_internal ? pmw_pkg::SRC_INTERNAL : src_of(ctrl.sys_clk_sel);

   // next clock enables from mode and source
   always_comb begin
      next_clk.clk_src = eff_src;
      next_clk.cpu_clk_en = (state == pmw_pkg::PMW_RUN);
      next_clk.periph_clk_en = (state != pmw_pkg::PMW_SLEEP) &&
                               (state != pmw_pkg::PMW_OST_WAIT);
      next_clk.primary_osc_en = (eff_src == pmw_pkg::SRC_PRIMARY) &&
                                (state != pmw_pkg::PMW_SLEEP);
      // internal oscillator kept for watchdog or monitor
      next_clk.internal_osc_en = ((eff_src == pmw_pkg::SRC_INTERNAL) &&
                                  (state != pmw_pkg::PMW_SLEEP)) ||
                                 ctrl.wdt_en || ctrl.fscm_en;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_clk <= '0;
      end else begin
         o_clk <= next_clk;
      end
   end

   // running flag cleared when primary stops
   // external clock needs no start-up wait
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_primary_clock_running <= 1'b0;
      end else if (!next_clk.primary_osc_en) begin
         o_primary_clock_running <= 1'b0;
      end else if (i_ost_done || ctrl.ext_clk_mode) begin
         o_primary_clock_running <= 1'b1;
      end
   end

   assign o_ost_req = o_clk.primary_osc_en && !o_primary_clock_running && !ctrl.ext_clk_mode;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   assign wr_en = wr_fire && w_strb[0];
   assign wr_rc = wr_en && (aw_addr == pmw_pkg::ADDR_RESET_CAUSE);
   assign wr_ctrl = wr_en && (aw_addr == pmw_pkg::ADDR_CTRL);
   assign wr_clr = wr_en && (aw_addr == pmw_pkg::ADDR_IRQ_CLEAR);

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         ctrl <= pmw_pkg::pmw_ctrl_t'(pmw_pkg::CTRL_RESET_VAL[6:0]);
      end else if (wr_ctrl) begin
         ctrl <= pmw_pkg::pmw_ctrl_t'(w_data[6:0]);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         rcause <= pmw_pkg::RC_RESET_VAL;
      end else begin
         if (wr_rc) begin
            rcause <= (rcause & ~pmw_pkg::RC_SW_MASK) | (w_data[7:0] & pmw_pkg::RC_SW_MASK);
         end
         if (i_cfg_mismatch_event) begin
            rcause[pmw_pkg::RC_CFG_MISMATCH] <= 1'b0;
         end
         if (i_reset_instr) begin
            rcause[pmw_pkg::RC_RESET_INSTR] <= 1'b0;
         end
         if (i_por_event) begin
            rcause[pmw_pkg::RC_POWER_ON] <= 1'b0;
            rcause[pmw_pkg::RC_WDT_TIMEOUT] <= 1'b1;
            rcause[pmw_pkg::RC_POWER_DOWN] <= 1'b1;
         end
         if (i_bor_event) begin
            rcause[pmw_pkg::RC_BROWN_OUT] <= 1'b0;
         end
         if (i_wdt_clear_instr) begin
            rcause[pmw_pkg::RC_WDT_TIMEOUT] <= 1'b1;
            rcause[pmw_pkg::RC_POWER_DOWN] <= 1'b1;
         end
         if (i_sleep_instr && state == pmw_pkg::PMW_RUN) begin
            rcause[pmw_pkg::RC_WDT_TIMEOUT] <= 1'b1;
            rcause[pmw_pkg::RC_POWER_DOWN] <= 1'b0;
         end
         if (i_wdt_timeout) begin
            rcause[pmw_pkg::RC_WDT_TIMEOUT] <= 1'b0;
         end
      end
   end

   assign o_interrupt_priority_en = rcause[pmw_pkg::RC_PRIO_EN];

   // sticky interrupt status, set wins over clear
   assign irq_events[pmw_pkg::IRQ_WAKE_DONE] = o_resume;
   assign irq_events[pmw_pkg::IRQ_WDT_RESET] = o_wdt_reset;
   assign irq_events[pmw_pkg::IRQ_CLK_LOST] = i_clk_lost && ctrl.fscm_en;
   assign irq_events[pmw_pkg::IRQ_RESET_EXIT] = reset_event && low_power;

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~(wr_clr ? w_data[pmw_pkg::IRQ_W-1:0] : '0)) | irq_events;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         irq_enable <= '0;
      end else if (wr_en && aw_addr == pmw_pkg::ADDR_IRQ_ENABLE) begin
         irq_enable <= w_data[pmw_pkg::IRQ_W-1:0];
      end
   end

   assign o_irq = |(irq_status & irq_enable);

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   // capture address and data in either order
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response after both parts
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pmw_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_mapped(aw_addr) ? pmw_pkg::RESP_OKAY : pmw_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // registers read as one word
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= pmw_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_mapped(s_axi_araddr) ? pmw_pkg::RESP_OKAY : pmw_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            pmw_pkg::ADDR_RESET_CAUSE: s_axi_rdata <= {24'h000000, rcause};
            pmw_pkg::ADDR_CTRL: s_axi_rdata <= {25'h0000000, ctrl};
            pmw_pkg::ADDR_STATUS: s_axi_rdata <= {24'h000000, force_internal,
                                                  o_primary_clock_running, o_clk.clk_src,
                                                  o_clk.cpu_clk_en, state};
            pmw_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status};
            pmw_pkg::ADDR_IRQ_ENABLE: s_axi_rdata <= {28'h0000000, irq_enable};
            default: s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ==== test/pmw_core_model.sv ====
// cpu core and interrupt source stand-in for the sequencer
// assumes bench commands arrive by non-blocking assignment on the clock
`timescale 1ns/1ps
module pmw_core_model (
   // clock and bench commands
   input wire logic i_sys_clk,
   input wire logic i_cmd_sleep,
   input wire logic [7:0] i_cmd_flags,
   input wire logic [7:0] i_cmd_en,
   // towards the sequencer
   output logic o_sleep_instr = 1'b0,
   output logic [7:0] o_irq_flags = 8'h00,
   output logic [7:0] o_irq_enables = 8'h00
);
   always_ff @(posedge i_sys_clk) begin
      o_sleep_instr <= i_cmd_sleep;
   end
   always_ff @(posedge i_sys_clk) begin
      o_irq_enables <= i_cmd_en;
      o_irq_flags <= i_cmd_flags;
   end
endmodule

// ==== test/pmw_power_wake_monitor.sv ====
// output relations of the power-mode sequencer
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module pmw_power_wake_monitor (
   // clock, reset, strobes
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic i_sleep_instr,
   input wire logic i_wdt_clear_instr,
   input wire logic i_wdt_timeout,
   input wire logic i_clk_lost,
   input wire logic s_axi_bvalid,
   // watched outputs
   input wire pmw_pkg::pmw_clk_t o_clk,
   input wire logic o_primary_clock_running,
   input wire logic o_resume,
   input wire logic o_vector_branch,
   input wire logic o_wdt_clear,
   input wire logic o_wdt_reset,
   input wire logic o_interrupt_priority_en
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   wdt_reset_cause_a: assert property (o_wdt_reset |-> $past(i_wdt_timeout))
      else $error("watchdog reset without time-out");
   wdt_clear_cause_a: assert property (o_wdt_clear |->
      $past(i_sleep_instr || i_wdt_clear_instr || i_clk_lost)) else $error("stray clear");
   watchdog_clear_instr_clears_a: assert property (i_wdt_clear_instr |=> o_wdt_clear)
      else $error("clear instruction ignored");
   vector_on_resume_a: assert property (o_vector_branch |-> o_resume)
      else $error("branch outside resume");
   resume_pulse_a: assert property (o_resume |=> !o_resume)
      else $error("resume longer than one cycle");
   idle_primary_off_a: assert property ((o_clk.clk_src == pmw_pkg::SRC_INTERNAL &&
      !o_clk.cpu_clk_en && o_clk.periph_clk_en) |->
      (!o_clk.primary_osc_en && !o_primary_clock_running))
      else $error("primary left on in idle");
   internal_osc_on_a: assert property ((o_clk.clk_src == pmw_pkg::SRC_INTERNAL &&
      o_clk.periph_clk_en) |-> o_clk.internal_osc_en) else $error("internal osc off");
   prio_by_write_a: assert property ($changed(o_interrupt_priority_en) |->
      (s_axi_bvalid || $past(s_axi_bvalid))) else $error("priority bit moved alone");
   // main scenarios reached
   cover property (o_resume && o_vector_branch);
   cover property (o_resume && !o_vector_branch);
   cover property (o_wdt_reset);
endmodule

// ==== test/pmw_power_wake_tb.sv ====
// self-checking bench for the power-mode sequencer
// assumes pmw_pkg and the design are compiled first
`timescale 1ns/1ps
module pmw_power_wake_tb;
   localparam int WD = 2;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} pmw_row_t;
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cmd_flags = 8'h00, cmd_en = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, cmd_sleep = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, i_ost_done = 1'b1, i_master_clear_n = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, i_sleep_instr;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] i_irq_flags, i_irq_enables;
   logic [6:0] ev = 7'h00; // rst instr, cfg, por, bor, watchdog_clear_instr, timeout, clk lost
   pmw_pkg::pmw_clk_t o_clk;
   logic o_primary_clock_running, o_ost_req, o_resume, o_vector_branch;
   logic o_wdt_clear, o_wdt_reset, o_interrupt_priority_en, o_irq;
   int n_mismatch = 0, samples_checked = 0, n;
   pmw_row_t rows [5] = '{'{8'h00, 32'h3C, 2'h0}, '{8'h04, 32'h04, 2'h0},
      '{8'h0C, 32'h0, 2'h0}, '{8'h14, 32'h0, 2'h0}, '{8'h18, 32'h0, 2'h2}};
   // clock
   always #12.5 i_sys_clk = ~i_sys_clk;
   pmw_power_wake #(.WAKE_DELAY_CYC(WD)) u_pmw_power_wake (.i_sys_clk, .i_resetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .i_sleep_instr, .i_wdt_clear_instr(ev[4]),
      .i_reset_instr(ev[0]), .i_irq_flags, .i_irq_enables, .i_wdt_timeout(ev[5]),
      .i_clk_lost(ev[6]), .i_ost_done, .i_por_event(ev[2]), .i_bor_event(ev[3]),
      .i_cfg_mismatch_event(ev[1]), .i_master_clear_n, .o_clk, .o_primary_clock_running,
      .o_ost_req(), .o_resume, .o_vector_branch, .o_wdt_clear, .o_wdt_reset,
      .o_interrupt_priority_en, .o_irq);
   pmw_core_model u_pmw_core_model (.i_sys_clk, .i_cmd_sleep(cmd_sleep),
      .i_cmd_flags(cmd_flags), .i_cmd_en(cmd_en), .o_sleep_instr(i_sleep_instr),
      .o_irq_flags(i_irq_flags), .o_irq_enables(i_irq_enables));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge i_sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge i_sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic pulse(input int i);
      @(posedge i_sys_clk);
      ev[i] <= 1'b1;
      @(posedge i_sys_clk);
      ev[i] <= 1'b0;
      #1;
   endtask
   task automatic go_sleep;
      @(posedge i_sys_clk);
      cmd_sleep <= 1'b1;
      @(posedge i_sys_clk);
      cmd_sleep <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic wake_wait;
      n = 0;
      do begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end while (!o_resume && n < 40);
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (4000) @(posedge i_sys_clk);
      n_mismatch++;
      $display("unexpected at %0t: run hung", $time);
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i].a);
         chk(d, rows[i].d);
         chk(r, rows[i].r);
      end
      $display("reset values done");
      wr(8'h00, 32'hFF);
      rd(8'h00);
      chk(d, 32'hBF);
      chk(o_interrupt_priority_en, 1);
      pulse(3);
      rd(8'h00);
      chk(d, 32'hBE);
      wr(8'h00, 32'h00);
      rd(8'h00);
      chk(d, 32'h0C);
      $display("reset cause done");
      pulse(4);
      chk(o_wdt_clear, 1);
      pulse(5);
      chk(o_wdt_reset, 1);
      $display("watchdog in run done");
      cmd_en <= 8'h01;
      wr(8'h14, 32'h01);
      wr(8'h04, 32'h09);
      go_sleep();
      chk(o_clk, 32'h16);
      chk(o_primary_clock_running, 0);
      cmd_flags <= 8'h02;
      rd(8'h08);
      chk(d, 32'h21);
      @(posedge i_sys_clk);
      cmd_flags <= 8'h03;
      wake_wait();
      chk(n, WD + 2);
      chk(o_vector_branch, 1);
      @(posedge i_sys_clk);
      #1;
      chk(o_irq, 1);
      wr(8'h14, 32'h00);
      chk(o_irq, 0);
      wr(8'h14, 32'h01);
      chk(o_irq, 1);
      wr(8'h10, 32'h01);
      chk(o_irq, 0);
      rd(8'h04);
      chk(d, 32'h09);
      $display("interrupt wake done");
      cmd_flags <= 8'h00;
      go_sleep();
      pulse(5);
      chk(o_wdt_reset, 0);
      wake_wait();
      chk(n, WD);
      chk(o_vector_branch, 0);
      rd(8'h04);
      chk(d, 32'h09);
      $display("watchdog wake done");
      wr(8'h04, 32'h05);
      go_sleep();
      pulse(5);
      wake_wait();
      chk(n, WD);
      go_sleep();
      pulse(0);
      wake_wait();
      chk(n, WD);
      rd(8'h08);
      chk(d, 32'hA8);
      $display("reset exit done");
      wrap_up();
   end
endmodule
bind pmw_power_wake pmw_power_wake_monitor u_pmw_power_wake_monitor (.*);
